/* File: spi_flags_pkg.sv */
`default_nettype none
package spi_flags_pkg;
  // Widths
  localparam int DATA_W      = 8;
  localparam int SYNC_STAGES = 2;
  // Reset values of the held bits
  localparam logic [DATA_W-1:0] RX_DATA_RST = 8'h00;
  localparam logic [DATA_W-1:0] TX_DATA_RST = 8'h00;
  localparam logic SERIAL_ENABLE_RST  = 1'h0;
  localparam logic MASTER_SELECT_RST  = 1'h0;
  localparam logic FAULT_DETECT_RST   = 1'h0;
  localparam logic MODE_FAULT_RST     = 1'h0;
  localparam logic RECEIVE_FULL_RST   = 1'h0;
  localparam logic TRANSMIT_EMPTY_RST = 1'h1;
  localparam logic ARM_RST            = 1'h0;
  localparam logic IRQ_RST            = 1'h0;
  localparam logic ABORT_RST          = 1'h0;
  localparam logic PINS_OE_RST        = 1'h0;
  // Level the master select bit takes on a mode fault
  localparam logic MASTER_ON_FAULT    = 1'h0;
  // Idle level of the active-low slave-select pin
  localparam logic SS_IDLE_LVL        = 1'h1;
endpackage
`default_nettype wire

/* File: spi_ss_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_ss_sync
  import spi_flags_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  import spi_flags_pkg::*;

  logic [SYNC_STAGES-1:0] stage_r;
  logic [SYNC_STAGES-1:0] stage_nxt;

  // Shift the pin level through the chain
  always_comb begin
    stage_nxt = {stage_r[SYNC_STAGES-2:0], async_i};
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stage_r <= {SYNC_STAGES{SS_IDLE_LVL}};
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign sync_o = stage_r[SYNC_STAGES-1];
endmodule
`default_nettype wire

/* File: spi_interrupt_flags.sv */
// How it works
// - No interrupt request while the serial enable bit is clear.
// - Request is OR of mode fault, receive full and transmit empty flags.
// - Mode fault sets only as enabled master with detection and low select.
// - Mode fault aborts the transfer and clears the master select bit.
// - Mode fault request holds while its flag is set, drops when cleared.
// - Receive full sets when a new byte lands in the data register.
// - A transfer ending while receive full is set is discarded unless a clearing data read comes in the same cycle.
// - Transmit empty sets when the data register can take a byte.
// - Mode fault clears by status read with flag set, then control write.
// - With fault detect enable clear, mode fault never sets.
// - Mode fault drops all pin drivers and returns the link to idle.
`timescale 1ns/1ps
`default_nettype none
module spi_interrupt_flags
  import spi_flags_pkg::*;
(
  input  wire logic                             mclk_i,
  input  wire logic                             arst_n_i,
  input  wire logic                             ctrl1_wr_i,
  input  wire logic                             serial_enable_wdata_i,
  input  wire logic                             master_select_wdata_i,
  input  wire logic                             fault_detect_wdata_i,
  input  wire logic                             status_rd_i,
  input  wire logic                             data_rd_i,
  input  wire logic                             data_wr_i,
  input  wire logic [spi_flags_pkg::DATA_W-1:0] data_wdata_i,
  input  wire logic                             xfer_done_i,
  input  wire logic [spi_flags_pkg::DATA_W-1:0] rx_byte_i,
  input  wire logic                             tx_taken_i,
  input  wire logic                             slave_select_n_i,
  output logic                                  serial_enable_bit_o,
  output logic                                  master_select_bit_o,
  output logic                                  fault_detect_enable_o,
  output logic                                  mode_fault_flag_o,
  output logic                                  receive_full_flag_o,
  output logic                                  transmit_empty_flag_o,
  output logic      [spi_flags_pkg::DATA_W-1:0] rx_data_o,
  output logic      [spi_flags_pkg::DATA_W-1:0] tx_data_o,
  output logic                                  irq_o,
  output logic                                  abort_o,
  output logic                                  pins_oe_o
);
  import spi_flags_pkg::*;

  // Arm a clearing sequence on a status read that sees the flag set
  function automatic logic arm_next(input logic arm, input logic flag,
                                    input logic rd, input logic clr);
    arm_next = clr ? ARM_RST : (arm | (rd & flag));
  endfunction

  // Held state, next values and decoded strobes
  logic              ss_n_sync;
  logic              se_r, se_nxt;
  logic              ms_r, ms_nxt;
  logic              fd_r, fd_nxt;
  logic              mf_r, mf_nxt, mf_arm_r, mf_arm_nxt;
  logic              rf_r, rf_nxt, rf_arm_r, rf_arm_nxt;
  logic              te_r, te_nxt, te_arm_r, te_arm_nxt;
  logic [DATA_W-1:0] rx_r, rx_nxt;
  logic [DATA_W-1:0] tx_r, tx_nxt;
  logic              irq_r, irq_nxt;
  logic              abort_r, abort_nxt;
  logic              oe_r, oe_nxt;
  logic              fault_cond;
  logic              mf_clr;
  logic              rf_clr;
  logic              te_clr;
  logic              accept;

  // Slave-select pin into the clock domain
  spi_ss_sync u_ss_sync (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .async_i  (slave_select_n_i),
    .sync_o   (ss_n_sync)
  );

  // Next values of control bits, flags and data
  always_comb begin
    fault_cond = se_r & ms_r & fd_r & ~ss_n_sync;
    mf_clr     = mf_arm_r & ctrl1_wr_i;
    rf_clr     = rf_arm_r & data_rd_i;
    te_clr     = te_arm_r & data_wr_i;
    accept     = xfer_done_i & (~rf_r | rf_clr);
    // Control register one bits; a fault takes master away
    se_nxt     = ctrl1_wr_i ? serial_enable_wdata_i : se_r;
    fd_nxt     = ctrl1_wr_i ? fault_detect_wdata_i : fd_r;
    if (fault_cond) begin
      ms_nxt = MASTER_ON_FAULT;
    end else if (ctrl1_wr_i) begin
      ms_nxt = master_select_wdata_i;
    end else begin
      ms_nxt = ms_r;
    end
    // Set wins over clear for every flag
    mf_nxt     = fault_cond | (mf_r & ~mf_clr);
    mf_arm_nxt = arm_next(mf_arm_r, mf_r, status_rd_i, mf_clr);
    rf_nxt     = accept | (rf_r & ~rf_clr);
    rf_arm_nxt = arm_next(rf_arm_r, rf_r, status_rd_i, rf_clr);
    te_nxt     = tx_taken_i | (te_r & ~te_clr);
    te_arm_nxt = arm_next(te_arm_r, te_r, status_rd_i, te_clr);
    rx_nxt     = accept ? rx_byte_i : rx_r;
    // Writes while the data register is full are ignored
    tx_nxt     = (data_wr_i & te_r) ? data_wdata_i : tx_r;
    // Request and pin drive use next-cycle state
    irq_nxt    = se_nxt & (mf_nxt | rf_nxt | te_nxt);
    abort_nxt  = fault_cond;
    oe_nxt     = se_nxt & ms_nxt & ~mf_nxt;
  end

  // Register everything
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      se_r     <= SERIAL_ENABLE_RST;
      ms_r     <= MASTER_SELECT_RST;
      fd_r     <= FAULT_DETECT_RST;
      mf_r     <= MODE_FAULT_RST;
      mf_arm_r <= ARM_RST;
      rf_r     <= RECEIVE_FULL_RST;
      rf_arm_r <= ARM_RST;
      te_r     <= TRANSMIT_EMPTY_RST;
      te_arm_r <= ARM_RST;
      rx_r     <= RX_DATA_RST;
      tx_r     <= TX_DATA_RST;
      irq_r    <= IRQ_RST;
      abort_r  <= ABORT_RST;
      oe_r     <= PINS_OE_RST;
    end else begin
      se_r     <= se_nxt;
      ms_r     <= ms_nxt;
      fd_r     <= fd_nxt;
      mf_r     <= mf_nxt;
      mf_arm_r <= mf_arm_nxt;
      rf_r     <= rf_nxt;
      rf_arm_r <= rf_arm_nxt;
      te_r     <= te_nxt;
      te_arm_r <= te_arm_nxt;
      rx_r     <= rx_nxt;
      tx_r     <= tx_nxt;
      irq_r    <= irq_nxt;
      abort_r  <= abort_nxt;
      oe_r     <= oe_nxt;
    end
  end

  // Outputs straight from flops
  assign serial_enable_bit_o   = se_r;
  assign master_select_bit_o   = ms_r;
  assign fault_detect_enable_o = fd_r;
  assign mode_fault_flag_o     = mf_r;
  assign receive_full_flag_o   = rf_r;
  assign transmit_empty_flag_o = te_r;
  assign rx_data_o             = rx_r;
  assign tx_data_o             = tx_r;
  assign irq_o                 = irq_r;
  assign abort_o               = abort_r;
  assign pins_oe_o             = oe_r;

  // Checks on the flag logic
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_irq_needs_enable: assert property (!se_r |-> !irq_r)
    else $error("request while serial enable clear");
  a_irq_or_flags: assert property (irq_r ==
      (se_r & (mf_r | rf_r | te_r)))
    else $error("request does not match flags");
  a_fault_cause: assert property ($rose(mf_r) |->
      $past(se_r && ms_r && fd_r && !ss_n_sync))
    else $error("mode fault without cause");
  a_fault_drops_master: assert property ($rose(mf_r) |->
      !ms_r && abort_r ##1 !abort_r)
    else $error("fault did not clear master and abort once");
  a_fault_irq_hold: assert property (mf_r && se_r |-> irq_r)
    else $error("fault request missing");
  a_rx_capture: assert property (xfer_done_i && !rf_r |=>
      rf_r && rx_r == $past(rx_byte_i))
    else $error("received byte not captured");
  a_rx_discard: assert property (xfer_done_i && rf_r && !rf_clr |=>
      $stable(rx_r) && rf_r)
    else $error("byte overwritten while full");
  a_tx_empty_set: assert property (tx_taken_i |=> te_r)
    else $error("transmit empty not set");
  a_fault_clear_seq: assert property ($fell(mf_r) |->
      $past(mf_arm_r && ctrl1_wr_i))
    else $error("mode fault cleared without sequence");
  a_fault_gated: assert property (!fd_r && !mf_r |=> !mf_r)
    else $error("fault set with detect disabled");
  a_fault_no_drive: assert property (mf_r |-> !oe_r)
    else $error("pins driven during fault");
  a_flag_clear_seq: assert property (($fell(rf_r) |->
      $past(rf_arm_r && data_rd_i)) and ($fell(te_r) |->
      $past(te_arm_r && data_wr_i)))
    else $error("flag cleared without sequence");

  // Setting, loading, arming and drive checks
  a_fault_set_done: assert property (se_r && ms_r && fd_r &&
      !ss_n_sync |=> mf_r && !ms_r && abort_r)
    else $error("fault condition did not set the flag");
  a_abort_cause: assert property (abort_r |-> mf_r && !ms_r)
    else $error("abort without a mode fault");
  a_irq_drops_clear: assert property ($fell(mf_r) && !rf_r && !te_r |->
      !irq_r)
    else $error("fault request stayed after clear");
  a_tx_load: assert property (data_wr_i && te_r |=>
      tx_r == $past(data_wdata_i))
    else $error("transmit byte not loaded");
  a_tx_refused: assert property (data_wr_i && !te_r |=> $stable(tx_r))
    else $error("transmit byte overwritten while full");
  a_arm_mode_fault: assert property ($rose(mf_arm_r) |->
      $past(status_rd_i && mf_r))
    else $error("fault clear armed without status read");
  a_arm_receive: assert property ($rose(rf_arm_r) |->
      $past(status_rd_i && rf_r))
    else $error("receive clear armed without status read");
  a_arm_transmit: assert property ($rose(te_arm_r) |->
      $past(status_rd_i && te_r))
    else $error("transmit clear armed without status read");
  a_oe_master: assert property (oe_r |-> se_r && ms_r && !mf_r)
    else $error("pins driven outside enabled master");

  // Main scenarios reached
  c_fault: cover property ($rose(mf_r) ##[1:20] $fell(mf_r));
  c_overrun: cover property (xfer_done_i && rf_r && !rf_clr);
  c_rx_clear: cover property ($rose(rf_r) ##[1:20] $fell(rf_r));
  c_tx_clear: cover property ($fell(te_r) ##[1:60] $rose(te_r));
  c_tx_refused: cover property (data_wr_i && !te_r);
endmodule
`default_nettype wire

/* File: irq_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_sink (
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  input  wire logic       irq_i,
  output logic      [3:0] irq_cnt_o
);
  logic irq_r;
  // Processor side counts each new request it sees
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_r     <= 1'h0;
      irq_cnt_o <= 4'h0;
    end else begin
      irq_r <= irq_i;
      if (irq_i && !irq_r) irq_cnt_o <= irq_cnt_o + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: tb_spi_interrupt_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_spi_interrupt_flags;
  import spi_flags_pkg::*;
  logic              mclk_i = 1'h0;
  logic              arst_n_i = 1'h0;
  logic              cw, se, ms, fd, sr, dr, dw, xd, tt, ss_n;
  logic [DATA_W-1:0] wd, rb, rx_o, tx_o;
  logic              se_o, ms_o, fd_o, mf_o, rf_o, te_o, irq_o, ab_o, oe_o;
  logic [3:0]        irq_cnt;
  int                fail_count = 0;
  int                checks = 0;
  int                cyc = 0;
  // Free-running 200 MHz clock
  always #2.5 mclk_i = ~mclk_i;
  spi_interrupt_flags u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .ctrl1_wr_i(cw), .serial_enable_wdata_i(se),
    .master_select_wdata_i(ms), .fault_detect_wdata_i(fd),
    .status_rd_i(sr), .data_rd_i(dr), .data_wr_i(dw), .data_wdata_i(wd),
    .xfer_done_i(xd), .rx_byte_i(rb), .tx_taken_i(tt),
    .slave_select_n_i(ss_n), .serial_enable_bit_o(se_o),
    .master_select_bit_o(ms_o), .fault_detect_enable_o(fd_o),
    .mode_fault_flag_o(mf_o), .receive_full_flag_o(rf_o),
    .transmit_empty_flag_o(te_o), .rx_data_o(rx_o), .tx_data_o(tx_o),
    .irq_o(irq_o), .abort_o(ab_o), .pins_oe_o(oe_o));
  irq_sink u_sink (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .irq_i(irq_o),
    .irq_cnt_o(irq_cnt));
  task automatic step(int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Compare a single flag or control bit
  task automatic chk_bit(logic got, logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t bit got %h exp %h", $time, got, exp);
    end
  endtask
  // Compare a byte or a count
  task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle strobe, then one idle cycle
  task automatic hit(ref logic s);
    s = 1'h1;
    step();
    s = 1'h0;
    step();
  endtask
  task automatic ctrl(logic s, logic m, logic f);
    se = s;
    ms = m;
    fd = f;
    hit(cw);
  endtask
  task automatic results();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 500) begin
      fail_count++;
      results();
    end
  end
  initial begin
    {cw, se, ms, fd, sr, dr, dw, xd, tt} = '0;
    ss_n = 1'h1;
    wd = 8'h00;
    rb = 8'h00;
    repeat (4) @(posedge mclk_i);
    #1 arst_n_i = 1'h1;
    step();
    chk_bit(te_o, 1'h1);
    chk_bit(irq_o, 1'h0);
    chk_byte(rx_o, 8'h00);
    ctrl(1'h1, 1'h1, 1'h0);
    chk_bit(se_o, 1'h1);
    chk_bit(irq_o, 1'h1);
    chk_bit(oe_o, 1'h1);
    chk_byte({4'h0, irq_cnt}, 8'h01);
    hit(sr);
    wd = 8'hA5;
    hit(dw);
    chk_bit(te_o, 1'h0);
    chk_byte(tx_o, 8'hA5);
    chk_bit(irq_o, 1'h0);
    wd = 8'h3C;
    hit(dw);
    chk_byte(tx_o, 8'hA5);
    rb = 8'h5A;
    hit(xd);
    chk_byte(rx_o, 8'h5A);
    chk_bit(rf_o, 1'h1);
    chk_bit(irq_o, 1'h1);
    rb = 8'h77;
    hit(xd);
    chk_byte(rx_o, 8'h5A);
    hit(dr);
    chk_bit(rf_o, 1'h1);
    hit(sr);
    hit(dr);
    chk_bit(rf_o, 1'h0);
    ss_n = 1'h0;
    step(6);
    chk_bit(mf_o, 1'h0);
    chk_bit(ms_o, 1'h1);
    ss_n = 1'h1;
    step(3);
    ctrl(1'h1, 1'h1, 1'h1);
    chk_bit(fd_o, 1'h1);
    ss_n = 1'h0;
    step(2);
    chk_bit(mf_o, 1'h0);
    step();
    chk_bit(mf_o, 1'h1);
    chk_bit(ab_o, 1'h1);
    chk_bit(ms_o, 1'h0);
    chk_bit(oe_o, 1'h0);
    chk_bit(irq_o, 1'h1);
    step();
    chk_bit(ab_o, 1'h0);
    ss_n = 1'h1;
    ctrl(1'h1, 1'h0, 1'h1);
    chk_bit(mf_o, 1'h1);
    hit(sr);
    ctrl(1'h1, 1'h0, 1'h1);
    chk_bit(mf_o, 1'h0);
    chk_bit(irq_o, 1'h0);
    hit(tt);
    chk_bit(te_o, 1'h1);
    chk_bit(irq_o, 1'h1);
    ctrl(1'h0, 1'h0, 1'h0);
    chk_bit(irq_o, 1'h0);
    chk_bit(se_o, 1'h0);
    chk_byte({4'h0, irq_cnt}, 8'h04);
    results();
  end
endmodule
`default_nettype wire
